// ---- verilog/lcd_cmd_decoder.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "lcd_defs.svh"
module lcd_cmd_decoder #(
    parameter int FIFO_DEPTH = `LCD_FIFO_DEPTH,
    // identity and version values are arbitrary
    parameter logic IDENT = 1'b0,
    parameter logic [1:0] VERSION = 2'h1,
    parameter logic MODE = 1'b0,
    parameter logic MODE_SEL = 1'b0
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic pix_valid,
    output logic [7:0] pix_data,
    input wire logic pix_ready,
    input wire logic [7:0] disp_rdata,
    output logic disp_rd_pulse,
    output logic [5:0] page_pointer,
    output logic partial_en,
    output logic [1:0] shade1,
    output logic [1:0] shade2,
    output logic [7:0] partial_start_line,
    output logic [7:0] partial_end_line,
    output logic [4:0] nv_operation_ctrl,
    output logic column_mirror_flag,
    output logic row_mirror_flag,
    output logic display_enabled_flag
);
    // decoder state and latched opcode awaiting its parameter
    lcd_pkg::lcd_state_e state_reg;
    logic [7:0] op_reg;
    logic [7:0] advanced_ctrl_regs [6];
    // bus data phase bookkeeping
    logic pend_reg;
    logic wr_reg;
    logic [7:0] addr_reg;
    // fifo wiring
    lcd_pkg::lcd_entry_s in_ent;
    lcd_pkg::lcd_entry_s ent;
    logic f_in_valid;
    logic f_in_ready;
    logic f_out_valid;
    logic pop;
    logic done;
    logic rd_rx;
    logic opc;
    logic par;

    // opcodes followed by one parameter byte; others are single byte
    function automatic logic needs_param(input logic [7:0] op);
        logic r;
        r = 1'b0;
        casez (op)
            8'b0000_0100, 8'b1000_0001, 8'b1100_100?: r = 1'b1;
            8'b0011_0???: r = op[2:0] <= `LCD_APC_LAST;
            8'b1110_0001, 8'b1110_01??, 8'b1011_100?: r = 1'b1;
            8'b1111_0001, 8'b1111_001?, 8'b1111_01??: r = 1'b1;
            8'b1111_101?, 8'b1111_110?: r = 1'b1;
            default: r = 1'b0;
        endcase
        return r;
    endfunction : needs_param

    // data phase completes once its target can take it
    assign in_ent = '{cd: hwdata[`LCD_TX_CD_BIT], data: hwdata[7:0]};
    assign f_in_valid = pend_reg && wr_reg && (addr_reg == `LCD_OFS_TX);
    // a read of the rx register waits for every queued write to be decoded first
    assign rd_rx = pend_reg && !wr_reg && (addr_reg == `LCD_OFS_RX);
    assign done = pend_reg && (f_in_valid ? f_in_ready
                              : (!rd_rx || !f_out_valid));
    // stall the queue while a pixel byte is still unaccepted
    assign pop = f_out_valid && (!pix_valid || pix_ready);
    assign opc = pop && !ent.cd;
    assign par = pop && ent.cd && state_reg == lcd_pkg::LCD_PARAM;

    // command byte queue; full queue holds off the bus write
    lcd_fifo #(
        .WIDTH($bits(lcd_pkg::lcd_entry_s)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(hclk),
        .rst_n(hresetn),
        .in_valid(f_in_valid),
        .in_ready(f_in_ready),
        .in_data(in_ent),
        .out_valid(f_out_valid),
        .out_ready(pop),
        .out_data(ent)
    );

    // ahb-lite slave: one wait state minimum, always okay
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_reg <= 1'b0;
            wr_reg <= 1'b0;
            addr_reg <= 8'h00;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else if (hsel && htrans[1] && hready) begin
            pend_reg <= 1'b1;
            wr_reg <= hwrite;
            addr_reg <= haddr[7:0];
            hreadyout <= 1'b0;
        end else if (done) begin
            pend_reg <= 1'b0;
            hreadyout <= 1'b1;
        end
    end

    // read data; unmapped and write-only offsets read zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (done && !wr_reg) begin
            case (addr_reg)
                `LCD_OFS_RX: begin
                    case (state_reg)
                        lcd_pkg::LCD_STAT1: hrdata <= {24'h00_0000,
                            `LCD_POR_FLAG, column_mirror_flag,
                            row_mirror_flag, IDENT, display_enabled_flag,
                            display_enabled_flag, MODE, MODE_SEL};
                        // programming control reads zero, engine absent
                        lcd_pkg::LCD_STAT2:
                            hrdata <= {24'h00_0000, VERSION, 6'h00};
                        lcd_pkg::LCD_RDATA:
                            hrdata <= {24'h00_0000, disp_rdata};
                        default: hrdata <= 32'h0000_0000;
                    endcase
                end
                `LCD_OFS_SET0: hrdata <= {16'h0000, shade2, shade1,
                    partial_en, display_enabled_flag, row_mirror_flag,
                    column_mirror_flag, 2'h0, page_pointer};
                `LCD_OFS_SET1: hrdata <= {11'h000, nv_operation_ctrl,
                    partial_end_line, partial_start_line};
                `LCD_OFS_APC0: hrdata <= {advanced_ctrl_regs[3],
                    advanced_ctrl_regs[2], advanced_ctrl_regs[1],
                    advanced_ctrl_regs[0]};
                `LCD_OFS_APC1: hrdata <= {16'h0000, advanced_ctrl_regs[5],
                    advanced_ctrl_regs[4]};
                `LCD_OFS_STAT: hrdata <= {24'h00_0000, f_in_ready,
                    f_out_valid, pix_valid, state_reg, op_reg[1:0]};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // decoder state: opcodes, parameter capture, read advance
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= lcd_pkg::LCD_IDLE;
            op_reg <= 8'h00;
        end else if (opc) begin
            // any opcode ends a running stream
            op_reg <= ent.data;
            casez (ent.data)
                8'b0000_0001: state_reg <= lcd_pkg::LCD_WDATA;
                8'b0000_0010: state_reg <= lcd_pkg::LCD_RDATA;
                8'b0000_0011: state_reg <= lcd_pkg::LCD_STAT1;
                default: state_reg <= needs_param(ent.data)
                    ? lcd_pkg::LCD_PARAM : lcd_pkg::LCD_IDLE;
            endcase
        end else if (par) begin
            state_reg <= lcd_pkg::LCD_IDLE;
        end else if (done && rd_rx) begin
            case (state_reg)
                lcd_pkg::LCD_STAT1: state_reg <= lcd_pkg::LCD_STAT2;
                lcd_pkg::LCD_STAT2: state_reg <= lcd_pkg::LCD_IDLE;
                default: state_reg <= state_reg;
            endcase
        end
    end

    // display data stream toward the panel memory port
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pix_valid <= 1'b0;
            pix_data <= 8'h00;
        end else if (pop && ent.cd && state_reg == lcd_pkg::LCD_WDATA) begin
            pix_valid <= 1'b1;
            pix_data <= ent.data;
        end else if (pix_ready) begin
            pix_valid <= 1'b0;
        end
    end

    // one pulse per data read so the memory side can step its address
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            disp_rd_pulse <= 1'b0;
        end else begin
            disp_rd_pulse <= done && rd_rx
                && state_reg == lcd_pkg::LCD_RDATA;
        end
    end

    // single-byte setting opcodes; settings hold otherwise
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            page_pointer <= `LCD_RST_PAGE;
            partial_en <= 1'b0;
            shade1 <= `LCD_RST_SHADE1;
            shade2 <= `LCD_RST_SHADE2;
            column_mirror_flag <= 1'b0;
            row_mirror_flag <= 1'b0;
        end else if (opc) begin
            casez (ent.data)
                8'b0110_????: page_pointer[3:0] <= ent.data[3:0];
                8'b0111_00??: page_pointer[5:4] <= ent.data[1:0];
                8'b1000_010?: partial_en <= ent.data[0];
                8'b1101_00??: shade1 <= ent.data[1:0];
                8'b1101_01??: shade2 <= ent.data[1:0];
                8'b1100_0??0: begin
                    row_mirror_flag <= ent.data[2];
                    column_mirror_flag <= ent.data[1];
                end
                default: page_pointer <= page_pointer;
            endcase
        end
    end

    // parameter bytes, stored according to the latched opcode
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            partial_start_line <= `LCD_RST_START;
            partial_end_line <= `LCD_RST_END;
            nv_operation_ctrl <= `LCD_RST_NV;
            display_enabled_flag <= 1'b0;
            for (int i = 0; i < 6; i++) begin
                advanced_ctrl_regs[i] <= 8'h00;
            end
        end else if (par) begin
            casez (op_reg)
                8'b0011_0???: advanced_ctrl_regs[op_reg[2:0]] <= ent.data;
                8'hf2: partial_start_line <= ent.data;
                8'hf3: partial_end_line <= ent.data;
                8'hb8: begin
                    // malformed byte leaves the field untouched
                    if (ent.data[7:5] == 3'h0) begin
                        nv_operation_ctrl <= ent.data[4:0];
                    end
                end
                8'hc9: begin
                    if (ent.data[7:2] == 6'h2b) begin
                        display_enabled_flag <= ent.data[0];
                    end
                end
                // write mask, timers, pots: no effect without nv engine
                default: partial_start_line <= partial_start_line;
            endcase
        end
    end

    // checks: each setting follows its popped byte by one cycle
    // page low nibble from its opcode
    a_page_low_load: assert property (
        @(posedge hclk) disable iff (!hresetn)
        opc && ent.data[7:4] == 4'h6 |=>
        page_pointer[3:0] == $past(ent.data[3:0]))
        else $error("page low nibble not loaded");
    // high bits must not disturb the low nibble
    a_page_high_load: assert property (
        @(posedge hclk) disable iff (!hresetn)
        opc && ent.data[7:2] == 6'h1c |=>
        page_pointer[5:4] == $past(ent.data[1:0]) &&
        page_pointer[3:0] == $past(page_pointer[3:0]))
        else $error("page high bits wrong");
    a_page_high_guard: assert property (
        @(posedge hclk) disable iff (!hresetn)
        opc && ent.data[7:4] == 4'h7 && ent.data[3:2] != 2'h0 |=>
        $stable(page_pointer))
        else $error("page changed by bad opcode");
    a_partial_enable: assert property (
        @(posedge hclk) disable iff (!hresetn)
        opc && ent.data[7:1] == 7'h42 |=>
        partial_en == $past(ent.data[0]))
        else $error("partial enable not stored");
    // each shade opcode leaves the other shade alone
    a_shade_one: assert property (
        @(posedge hclk) disable iff (!hresetn)
        opc && ent.data[7:2] == 6'h34 |=>
        shade1 == $past(ent.data[1:0]) && $stable(shade2))
        else $error("shade one wrong");
    a_shade_two: assert property (
        @(posedge hclk) disable iff (!hresetn)
        opc && ent.data[7:2] == 6'h35 |=>
        shade2 == $past(ent.data[1:0]) && $stable(shade1))
        else $error("shade two wrong");
    a_start_line: assert property (
        @(posedge hclk) disable iff (!hresetn)
        par && op_reg == 8'hf2 |=>
        partial_start_line == $past(ent.data))
        else $error("start line not stored");
    a_end_line: assert property (
        @(posedge hclk) disable iff (!hresetn)
        par && op_reg == 8'hf3 |=>
        partial_end_line == $past(ent.data))
        else $error("end line not stored");
    // a byte with its top bits set must not reach the field
    a_nv_guard: assert property (
        @(posedge hclk) disable iff (!hresetn)
        par && op_reg == 8'hb8 |=>
        nv_operation_ctrl == ($past(ent.data[7:5]) == 3'h0 ?
        $past(ent.data[4:0]) : $past(nv_operation_ctrl)))
        else $error("nv control field wrong");
    a_apc_store: assert property (
        @(posedge hclk) disable iff (!hresetn)
        par && op_reg[7:3] == 5'h06 |=>
        advanced_ctrl_regs[$past(op_reg[2:0])] == $past(ent.data))
        else $error("advanced control not stored");
    // a parameter byte never reaches the pixel stream
    a_param_not_pixel: assert property (
        @(posedge hclk) disable iff (!hresetn)
        par |=> state_reg == lcd_pkg::LCD_IDLE &&
        (pix_data == $past(pix_data)))
        else $error("parameter leaked to stream");
    // flags byte first, then the version byte, then back to idle
    a_status_pair: assert property (
        @(posedge hclk) disable iff (!hresetn)
        done && rd_rx && state_reg == lcd_pkg::LCD_STAT1 |=>
        state_reg == lcd_pkg::LCD_STAT2 && hrdata[7] == `LCD_POR_FLAG)
        else $error("status byte order wrong");
    a_status_version: assert property (
        @(posedge hclk) disable iff (!hresetn)
        done && rd_rx && state_reg == lcd_pkg::LCD_STAT2 |=>
        state_reg == lcd_pkg::LCD_IDLE && hrdata[7:6] == VERSION &&
        hrdata[5:0] == 6'h00)
        else $error("status version byte wrong");
    // no disable here: it must look at the first edge after release
    a_reset_values: assert property (
        @(posedge hclk)
        $rose(hresetn) |-> page_pointer == `LCD_RST_PAGE &&
        shade1 == `LCD_RST_SHADE1 && shade2 == `LCD_RST_SHADE2 &&
        partial_end_line == `LCD_RST_END && !partial_en)
        else $error("reset defaults wrong");

    c_stream: cover property (@(posedge hclk) disable iff (!hresetn)
        pix_valid && pix_ready);
    c_status: cover property (@(posedge hclk) disable iff (!hresetn)
        done && rd_rx && state_reg == lcd_pkg::LCD_STAT2);
    c_full: cover property (@(posedge hclk) disable iff (!hresetn)
        f_in_valid && !f_in_ready);
    // a parameter byte captured after its opcode
    c_param: cover property (@(posedge hclk) disable iff (!hresetn)
        par);
endmodule : lcd_cmd_decoder
`default_nettype wire

// ---- pkg/lcd_defs.svh ----
`ifndef LCD_DEFS_SVH
`define LCD_DEFS_SVH
// Behaviour
// - cd low opcode, high data; rw sets direction
// - don't-care opcode bits never affect matching
// - status opcode then two status read bytes
// - advanced control opcode index selects stored byte
// - page low opcode loads page bits 3..0
// - page high opcode loads page bits 5..4
// - partial control opcode stores partial enable
// - gray shade one setting, reset 01
// - gray shade two setting, reset 10
// - partial start parameter, reset zero
// - partial end parameter, reset 159
// - nv control needs top three zero
// - nv programming commands have no effect

// register byte offsets
`define LCD_OFS_TX 8'h00
`define LCD_OFS_RX 8'h04
`define LCD_OFS_SET0 8'h08
`define LCD_OFS_SET1 8'h0c
`define LCD_OFS_APC0 8'h10
`define LCD_OFS_APC1 8'h14
`define LCD_OFS_STAT 8'h18
// field position of the cd flag in the transfer register
`define LCD_TX_CD_BIT 8
// reset values
`define LCD_RST_PAGE 6'h00
`define LCD_RST_SHADE1 2'h1
`define LCD_RST_SHADE2 2'h2
`define LCD_RST_START 8'h00
`define LCD_RST_END 8'h9f
`define LCD_RST_NV 5'h10
`define LCD_POR_FLAG 1'b1
`define LCD_APC_LAST 3'h5
// data path buffer depth
`define LCD_FIFO_DEPTH 32
`endif

// ---- pkg/lcd_pkg.sv ----
package lcd_pkg;
    // decoder states, gray coded along idle-param and idle-read data paths
    typedef enum logic [2:0] {
        LCD_IDLE  = 3'h0,
        LCD_PARAM = 3'h1,
        LCD_WDATA = 3'h3,
        LCD_RDATA = 3'h2,
        LCD_STAT1 = 3'h6,
        LCD_STAT2 = 3'h7
    } lcd_state_e;
    // one host write cycle as queued toward the decoder
    typedef struct packed {
        logic cd;
        logic [7:0] data;
    } lcd_entry_s;
endpackage : lcd_pkg

// ---- verilog/lcd_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module lcd_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    // storage array; pointers carry one wrap bit
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_reg;
    logic [AW:0] rd_ptr_reg;
    logic push;
    logic pop;

    // full when pointers differ only in the wrap bit
    assign in_ready = (wr_ptr_reg ^ rd_ptr_reg) != {1'b1, {AW{1'b0}}};
    assign out_valid = wr_ptr_reg != rd_ptr_reg;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr_reg[AW-1:0]];

    // storage write, no reset needed on data
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg[AW-1:0]] <= in_data;
        end
    end

    // pointer update
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
        end
    end
endmodule : lcd_fifo
`default_nettype wire

// ---- verif/lcd_pix_sink.sv ----
`timescale 1ns/1ps
`default_nettype none
// far-side model: pixel byte sink plus display memory read source
module lcd_pix_sink (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic pix_valid,
    input wire logic [7:0] pix_data,
    output logic pix_ready,
    output logic [7:0] disp_rdata,
    input wire logic disp_rd_pulse,
    input wire logic hold,
    input wire logic slow
);
    logic [7:0] got_q[$]; // accepted bytes, in arrival order
    int rd_cnt = 0; // memory read strobes seen
    logic phase = 1'b0; // toggles each cycle for slow mode

    // slow mode stalls every other cycle, so back-pressure is exercised
    always @(posedge hclk) begin
        phase <= ~phase;
    end

    // hold keeps the sink fully stalled while the bench fills the buffer
    assign pix_ready = !hold && (!slow || phase);

    // a byte counts only on an edge with valid and ready both high
    always @(posedge hclk) begin
        if (pix_valid && pix_ready) begin
            got_q.push_back(pix_data);
        end
    end

    // memory data steps on each read strobe, so stale data shows up
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            disp_rdata <= 8'ha0;
            rd_cnt <= 0;
        end else if (disp_rd_pulse) begin
            disp_rdata <= disp_rdata + 8'h01;
            rd_cnt <= rd_cnt + 1;
        end
    end
endmodule : lcd_pix_sink
`default_nettype wire

// ---- verif/lcd_command_decoder_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "lcd_defs.svh"
module lcd_command_decoder_bench;
    // one table row: opcode, optional parameter, expected settings words
    typedef struct {
        logic [7:0] op;
        logic hasp;
        logic [7:0] par;
        logic [31:0] s0;
        logic [31:0] s1;
    } lcd_row_s;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, pix_valid, pix_ready, disp_rd_pulse;
    logic [7:0] pix_data, disp_rdata, st_line, end_line;
    logic [5:0] page;
    logic [1:0] sh1, sh2;
    logic [4:0] nv;
    logic part_en, colm, rowm, disp_en;
    logic sink_hold = 1'b1; // sink stalled until the buffer test frees it
    logic sink_slow = 1'b0;
    logic [31:0] rd; // last read word
    int error_cnt = 0;
    int samples_checked = 0;
    lcd_row_s rows[13];

    // 50 MHz bus clock
    always #10 hclk = ~hclk;

    // single slave, so its ready is the bus ready
    lcd_cmd_decoder dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .pix_valid(pix_valid), .pix_data(pix_data),
        .pix_ready(pix_ready), .disp_rdata(disp_rdata),
        .disp_rd_pulse(disp_rd_pulse), .page_pointer(page),
        .partial_en(part_en), .shade1(sh1), .shade2(sh2),
        .partial_start_line(st_line), .partial_end_line(end_line),
        .nv_operation_ctrl(nv), .column_mirror_flag(colm),
        .row_mirror_flag(rowm), .display_enabled_flag(disp_en)
    );

    lcd_pix_sink sink (
        .hclk(hclk), .hresetn(hresetn), .pix_valid(pix_valid),
        .pix_data(pix_data), .pix_ready(pix_ready),
        .disp_rdata(disp_rdata), .disp_rd_pulse(disp_rd_pulse),
        .hold(sink_hold), .slow(sink_slow)
    );

    // verdict and end of run, shared with the watchdog
    task automatic stop_test();
        $display("mismatches %0d, comparisons %0d", error_cnt,
                 samples_checked);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test

    // word comparison
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp,
                            input string what);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, what,
                     got, exp);
        end
    endtask : chk_word

    // byte comparison, for port levels
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp,
                            input string what);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, what,
                     got, exp);
        end
    endtask : chk_byte

    // one single transfer; no fixed latency, only the watchdog ends a wait
    task automatic ahb_xfer(input logic wr, input logic [7:0] a,
                            input logic [31:0] wd, output logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        d = hrdata;
        chk_byte({7'h0, hresp}, 8'h00, "response");
    endtask : ahb_xfer

    // one host byte with its command/data flag; only defined opcodes
    task automatic send(input logic cd, input logic [7:0] b);
        ahb_xfer(1'b1, `LCD_OFS_TX, {23'h0, cd, b}, rd);
    endtask : send

    // wait until every queued byte has been decoded
    task automatic settle();
        do ahb_xfer(1'b0, `LCD_OFS_STAT, 32'h0, rd); while (rd[6] !== 1'b0);
        repeat (2) @(posedge hclk);
    endtask : settle

    // hang guard, well above the expected run length
    initial begin
        #400000;
        error_cnt++;
        stop_test();
    end

    initial begin
        rows = '{
            '{8'h6a, 1'b0, 8'h00, 32'h900a, 32'h00109f00},
            '{8'h73, 1'b0, 8'h00, 32'h903a, 32'h00109f00},
            '{8'h85, 1'b0, 8'h00, 32'h983a, 32'h00109f00},
            '{8'hd2, 1'b0, 8'h00, 32'ha83a, 32'h00109f00},
            '{8'hd7, 1'b0, 8'h00, 32'he83a, 32'h00109f00},
            '{8'hf2, 1'b1, 8'h40, 32'he83a, 32'h00109f40},
            '{8'hf3, 1'b1, 8'h7e, 32'he83a, 32'h00107e40},
            '{8'hb8, 1'b1, 8'h0b, 32'he83a, 32'h000b7e40},
            '{8'hb9, 1'b1, 8'h3f, 32'he83a, 32'h000b7e40},
            '{8'hc6, 1'b0, 8'h00, 32'heb3a, 32'h000b7e40},
            '{8'hc9, 1'b1, 8'had, 32'hef3a, 32'h000b7e40},
            '{8'h6f, 1'b0, 8'h00, 32'hef3f, 32'h000b7e40},
            '{8'h84, 1'b0, 8'h00, 32'he73f, 32'h000b7e40}
        };
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb_xfer(1'b0, `LCD_OFS_SET0, 32'h0, rd);
        chk_word(rd, 32'h9000, "set0 reset");
        ahb_xfer(1'b0, `LCD_OFS_SET1, 32'h0, rd);
        chk_word(rd, 32'h00109f00, "set1 reset");
        // ordinary commands, settings accumulate row by row
        foreach (rows[i]) begin
            send(1'b0, rows[i].op);
            if (rows[i].hasp) begin
                send(1'b1, rows[i].par);
            end
            settle();
            ahb_xfer(1'b0, `LCD_OFS_SET0, 32'h0, rd);
            chk_word(rd, rows[i].s0, "set0 row");
            ahb_xfer(1'b0, `LCD_OFS_SET1, 32'h0, rd);
            chk_word(rd, rows[i].s1, "set1 row");
        end
        chk_byte(end_line, 8'h7e, "end line port");
        chk_byte({3'h0, nv}, 8'h0b, "nv port");
        chk_byte({2'h0, page}, 8'h3f, "page port");
        chk_byte(st_line, 8'h40, "start line port");
        chk_byte({4'h0, part_en, disp_en, rowm, colm}, 8'h07, "flag");
        // only the first data byte after the opcode is the parameter
        send(1'b0, 8'hf2);
        send(1'b1, 8'h12);
        send(1'b1, 8'h34);
        settle();
        ahb_xfer(1'b0, `LCD_OFS_SET1, 32'h0, rd);
        chk_word(rd, 32'h000b7e12, "second data byte");
        // every advanced control index
        for (int r = 0; r < 6; r++) begin
            send(1'b0, 8'h30 | 8'(r));
            send(1'b1, 8'((r + 1) * 17));
        end
        settle();
        ahb_xfer(1'b0, `LCD_OFS_APC0, 32'h0, rd);
        chk_word(rd, 32'h44332211, "adv regs 0-3");
        ahb_xfer(1'b0, `LCD_OFS_APC1, 32'h0, rd);
        chk_word(rd, 32'h00006655, "adv regs 4-5");
        // read-only write and unmapped place
        ahb_xfer(1'b1, `LCD_OFS_SET0, 32'hffffffff, rd);
        ahb_xfer(1'b1, 8'h1c, 32'hffffffff, rd);
        ahb_xfer(1'b0, 8'h1c, 32'h0, rd);
        chk_word(rd, 32'h0, "unmapped read");
        ahb_xfer(1'b0, `LCD_OFS_SET0, 32'h0, rd);
        chk_word(rd, 32'he73f, "read-only kept");
        // stream with stalled sink: one byte held, buffer filled to full
        send(1'b0, 8'h01);
        for (int i = 0; i < 33; i++) begin
            send(1'b1, 8'h10 + 8'(i));
        end
        repeat (4) @(posedge hclk);
        ahb_xfer(1'b0, `LCD_OFS_STAT, 32'h0, rd);
        chk_byte({5'h0, rd[7:5]}, 8'h03, "full, held byte");
        chk_byte(pix_data, 8'h10, "held byte");
        sink_hold <= 1'b0;
        sink_slow <= 1'b1;
        settle();
        chk_word(32'(sink.got_q.size()), 32'd33, "stream count");
        foreach (sink.got_q[i]) begin
            chk_byte(sink.got_q[i], 8'h10 + 8'(i), "stream byte");
        end
        // display memory reads, then the status pair and an extra read
        send(1'b0, 8'h02);
        ahb_xfer(1'b0, `LCD_OFS_RX, 32'h0, rd);
        chk_word(rd, 32'ha0, "mem read 1");
        ahb_xfer(1'b0, `LCD_OFS_RX, 32'h0, rd);
        chk_word(rd, 32'ha1, "mem read 2");
        repeat (2) @(posedge hclk);
        chk_word(32'(sink.rd_cnt), 32'd2, "read strobes");
        send(1'b0, 8'h03);
        ahb_xfer(1'b0, `LCD_OFS_RX, 32'h0, rd);
        chk_word(rd, 32'hec, "status flags");
        ahb_xfer(1'b0, `LCD_OFS_RX, 32'h0, rd);
        chk_word(rd, 32'h40, "status version");
        ahb_xfer(1'b0, `LCD_OFS_RX, 32'h0, rd);
        chk_word(rd, 32'h0, "status third read");
        // second reset in mid-run brings back both settings words and adv regs 0-3
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb_xfer(1'b0, `LCD_OFS_SET0, 32'h0, rd);
        chk_word(rd, 32'h9000, "set0 after reset");
        ahb_xfer(1'b0, `LCD_OFS_SET1, 32'h0, rd);
        chk_word(rd, 32'h00109f00, "set1 after reset");
        ahb_xfer(1'b0, `LCD_OFS_APC0, 32'h0, rd);
        chk_word(rd, 32'h0, "adv after reset");
        chk_byte({6'h0, sh1}, 8'h01, "shade1 port");
        chk_byte({6'h0, sh2}, 8'h02, "shade2 port");
        stop_test();
    end
endmodule : lcd_command_decoder_bench
`default_nettype wire
